/* File: bcc_pkg.sv */
// Package for the breaker command control block: modes, states, timing.
// Assumes a 125 MHz core clock; all timers count a derived 1 ms tick.
package bcc_pkg;

  // Core clock and tick derivation
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS_NUM     = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS_NUM;
  localparam int unsigned TICK_W          = 17;

  // Timer width in milliseconds (settings reach 60,000 ms)
  localparam int unsigned MS_W            = 16;

  // Default settings, in milliseconds
  localparam logic [15:0] OPER_TIME_MS    = 16'h03E8; // 1,000 ms
  localparam logic [15:0] PULSE_MS        = 16'h0064; // 100 ms
  localparam logic [15:0] INTERM_MS       = 16'h0064; // 100 ms
  localparam logic [15:0] SYNC_WAIT_MS    = 16'h03E8; // 1,000 ms
  localparam logic [15:0] SW_WAIT_MS      = 16'h0000; // 0 ms, disabled
  localparam logic [15:0] SELECT_MS       = 16'h1388; // 5,000 ms
  localparam logic [15:0] OPERATED_MS     = 16'h0096; // 150 ms fixed

  // Control models
  typedef enum logic [1:0] {
    BCC_DIRECT_NORMAL   = 2'h0,
    BCC_DIRECT_ENHANCED = 2'h1,
    BCC_SBO_ENHANCED    = 2'h2
  } bcc_model_type;

  // Command sequencer states, Gray coded in the order listed
  typedef enum logic [2:0] {
    BCC_IDLE     = 3'h0,
    BCC_SELECTED = 3'h1,
    BCC_SYNCWAIT = 3'h3,
    BCC_SWWAIT   = 3'h2,
    BCC_PULSE    = 3'h6,
    BCC_SUPERV   = 3'h7
  } bcc_state_type;

endpackage : bcc_pkg

/* File: bcc_pos_filter.sv */
// Breaker position filter: holds last valid end position, flags intermediate.
// Assumes feedback already synchronised and a 1 ms tick from the same clock.
`timescale 1ns/1ps
module bcc_pos_filter (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              tick_ms,
  // Feedback and setting
  input  wire logic              open_fb,
  input  wire logic              closed_fb,
  input  wire logic [15:0]       interm_time_ms,
  // Filtered state
  output logic                   opened,
  output logic                   closed,
  output logic                   intermediate,
  output logic                   bad
);

  logic [15:0] cnt_q, cnt_d;
  logic        opened_q, opened_d, closed_q, closed_d;
  logic        interm_q, interm_d, bad_q, bad_d;

  // Intermediate reported only after persisting past the wait time
  always_comb begin
    cnt_d    = cnt_q;
    opened_d = opened_q;
    closed_d = closed_q;
    interm_d = 1'b0;
    bad_d    = open_fb & closed_fb;
    if (open_fb ^ closed_fb) begin
      cnt_d    = '0;
      opened_d = open_fb;
      closed_d = closed_fb;
    end else if (!open_fb && !closed_fb) begin
      if (tick_ms && cnt_q < interm_time_ms) cnt_d = cnt_q + 16'h0001;
      interm_d = (cnt_q >= interm_time_ms);
      if (interm_d) begin
        opened_d = 1'b0;
        closed_d = 1'b0;
      end
    end else begin
      cnt_d    = '0;
      opened_d = 1'b0;
      closed_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q    <= '0;
      opened_q <= 1'b0;
      closed_q <= 1'b0;
      interm_q <= 1'b0;
      bad_q    <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      opened_q <= opened_d;
      closed_q <= closed_d;
      interm_q <= interm_d;
      bad_q    <= bad_d;
    end
  end

  assign opened       = opened_q;
  assign closed       = closed_q;
  assign intermediate = interm_q;
  assign bad          = bad_q;

endmodule : bcc_pos_filter

/* File: bcc_breaker_ctrl.sv */
// Breaker command control: takes local/remote open-close requests, checks
// permits, issues timed command pulses and supervises position feedback.
// Assumes pin inputs are asynchronous; requests are one-cycle core pulses.
// Summary of operation
// - Normal model: pass command, no supervision
// - Direct enhanced: check position, supervise outcome
// - SBO: select first, then supervised command
// - Flag failure past maximum operating time
// - Command output is one pulse of at most pulse length
// - Report intermediate only after wait time
// - Close waits sync permit, then starts synchroswitch
// - Selection discarded after select timeout
// - Operated pulse of 150 ms per operation
// - Flag position change without remote command or trip
// - Block input refuses breaker operation
// - Open/close only under matching permit
`timescale 1ns/1ps
module bcc_breaker_ctrl (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Command sources (enables are levels, requests one-cycle pulses, core domain)
  input  wire logic        local_enable,
  input  wire logic        remote_enable,
  input  wire logic        local_select,
  input  wire logic        remote_select,
  input  wire logic        local_open_req,
  input  wire logic        local_close_req,
  input  wire logic        remote_open_req,
  input  wire logic        remote_close_req,
  // Settings
  input  wire logic [1:0]  switching_control_model,
  input  wire logic [15:0] oper_time_ms,
  input  wire logic [15:0] pulse_time_ms,
  input  wire logic [15:0] interm_time_ms,
  input  wire logic [15:0] sync_wait_time,
  input  wire logic [15:0] synchroswitch_wait_time,
  input  wire logic [15:0] select_timeout,
  // Pins from breaker and interlocking (asynchronous)
  input  wire logic        sync_permit,
  input  wire logic        synchroswitch_pulse,
  input  wire logic        open_permit,
  input  wire logic        close_permit,
  input  wire logic        operation_block,
  input  wire logic        open_feedback,
  input  wire logic        closed_feedback,
  input  wire logic        external_trip_in,
  // Outputs
  output logic             open_command_pulse,
  output logic             close_command_pulse,
  output logic             synchroswitch_start,
  output logic             operated,
  output logic             unintended_operation,
  output logic             opened,
  output logic             closed,
  output logic             intermediate,
  output logic             bad_position,
  output logic             selected,
  output logic             operation_failed,
  output logic             command_refused
);

  // Two-flop synchronisers for all pin inputs, one generate loop
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw, sy1_q, sy2_q;
  assign pin_raw = {sync_permit, synchroswitch_pulse, open_permit, close_permit,
                    operation_block, open_feedback, closed_feedback, external_trip_in};
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        sy1_q[i] <= 1'b0;
        sy2_q[i] <= 1'b0;
      end else begin
        sy1_q[i] <= pin_raw[i];
        sy2_q[i] <= sy1_q[i];
      end
    end
  end
  logic s_sync, s_swp, s_openp, s_closep, s_block, s_ofb, s_cfb, s_trip;
  assign {s_sync, s_swp, s_openp, s_closep, s_block, s_ofb, s_cfb, s_trip} = sy2_q;

  // 1 ms tick divider
  logic [16:0] div_q, div_d;
  logic        tick_q, tick_d;
  always_comb begin
    tick_d = (div_q == 17'(bcc_pkg::TICK_CYCLES - 1));
    div_d  = tick_d ? '0 : div_q + 17'h0_0001;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // Position filter
  logic f_open, f_closed, f_interm, f_bad;
  bcc_pos_filter u_filter (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .tick_ms        (tick_q),
    .open_fb        (s_ofb),
    .closed_fb      (s_cfb),
    .interm_time_ms (interm_time_ms),
    .opened         (f_open),
    .closed         (f_closed),
    .intermediate   (f_interm),
    .bad            (f_bad)
  );

  // Request decode: source must be enabled
  logic req_open, req_close, req_sel, req_remote;
  logic enhanced, sbo;
  assign req_open   = (local_enable & local_open_req) | (remote_enable & remote_open_req);
  assign req_close  = (local_enable & local_close_req) | (remote_enable & remote_close_req);
  assign req_sel    = (local_enable & local_select) | (remote_enable & remote_select);
  assign req_remote = remote_enable & (remote_open_req | remote_close_req);
  assign enhanced   = switching_control_model != bcc_pkg::BCC_DIRECT_NORMAL;
  assign sbo        = switching_control_model == bcc_pkg::BCC_SBO_ENHANCED;

  // Sequencer state
  bcc_pkg::bcc_state_type st_q, st_d;
  logic [15:0] tmr_q, tmr_d;   // Phase timer (select, sync, switch, operating)
  logic [15:0] pls_q, pls_d;   // Command pulse timer
  logic        dir_q, dir_d;   // 1: close, 0: open
  logic        ocmd_q, ocmd_d, ccmd_q, ccmd_d, sws_q, sws_d;
  logic        fail_q, fail_d, ref_q, ref_d;
  logic        okpos, permit;

  always_comb begin
    okpos  = dir_q ? f_closed : f_open;
    permit = 1'b0;
    st_d   = st_q;
    tmr_d  = (tick_q && tmr_q != 16'hFFFF) ? tmr_q + 16'h0001 : tmr_q;
    pls_d  = (tick_q && pls_q != 16'h0000) ? pls_q - 16'h0001 : pls_q;
    dir_d  = dir_q;
    sws_d  = 1'b0;
    fail_d = 1'b0;
    ref_d  = 1'b0;
    ocmd_d = ocmd_q & (pls_d != 16'h0000);
    ccmd_d = ccmd_q & (pls_d != 16'h0000);
    unique case (st_q)
      bcc_pkg::BCC_IDLE: begin
        tmr_d = '0;
        if (sbo && req_sel) begin
          st_d = bcc_pkg::BCC_SELECTED;
        end else if (!sbo && (req_open || req_close)) begin
          dir_d = req_close;
          st_d  = bcc_pkg::BCC_SYNCWAIT;
        end
      end
      bcc_pkg::BCC_SELECTED: begin
        if (tmr_q >= select_timeout) begin
          st_d  = bcc_pkg::BCC_IDLE;
        end else if (req_open || req_close) begin
          dir_d = req_close;
          tmr_d = '0;
          st_d  = bcc_pkg::BCC_SYNCWAIT;
        end
      end
      bcc_pkg::BCC_SYNCWAIT: begin
        // Checks: block, permit, position already reached (enhanced models only)
        permit = dir_q ? s_closep : s_openp;
        if (s_block || !permit || (enhanced && okpos)) begin
          ref_d = 1'b1;
          st_d  = bcc_pkg::BCC_IDLE;
        end else if (!dir_q || s_sync) begin
          tmr_d  = '0;
          pls_d  = pulse_time_ms;
          ocmd_d = !dir_q;
          ccmd_d = dir_q;
          st_d   = bcc_pkg::BCC_PULSE;
        end else if (tmr_q >= sync_wait_time) begin
          tmr_d = '0;
          if (synchroswitch_wait_time == 16'h0000) begin
            st_d = bcc_pkg::BCC_IDLE;
          end else begin
            sws_d = 1'b1;
            st_d  = bcc_pkg::BCC_SWWAIT;
          end
        end
      end
      bcc_pkg::BCC_SWWAIT: begin
        // Close permit may drop while waiting for the switch pulse
        if (s_swp && !s_block && s_closep) begin
          tmr_d  = '0;
          pls_d  = pulse_time_ms;
          ccmd_d = 1'b1;
          st_d   = bcc_pkg::BCC_PULSE;
        end else if (tmr_q >= synchroswitch_wait_time) begin
          st_d = bcc_pkg::BCC_IDLE;
        end
      end
      bcc_pkg::BCC_PULSE: begin
        if (!enhanced) begin
          if (pls_d == 16'h0000) st_d = bcc_pkg::BCC_IDLE;
        end else begin
          st_d = bcc_pkg::BCC_SUPERV;
        end
      end
      bcc_pkg::BCC_SUPERV: begin
        if (okpos) begin
          ocmd_d = 1'b0;
          ccmd_d = 1'b0;
          pls_d  = '0;
          st_d   = bcc_pkg::BCC_IDLE;
        end else if (tmr_q >= oper_time_ms) begin
          fail_d = 1'b1;
          ocmd_d = 1'b0;
          ccmd_d = 1'b0;
          pls_d  = '0;
          st_d   = bcc_pkg::BCC_IDLE;
        end
      end
      default: st_d = bcc_pkg::BCC_IDLE;
    endcase
  end

  // Sequencer registers; sticky failure flag held until next command
  logic failst_q, failst_d;
  assign failst_d = fail_d | (failst_q & ~(st_q == bcc_pkg::BCC_SYNCWAIT));
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q     <= bcc_pkg::BCC_IDLE;
      tmr_q    <= '0;
      pls_q    <= '0;
      dir_q    <= 1'b0;
      ocmd_q   <= 1'b0;
      ccmd_q   <= 1'b0;
      sws_q    <= 1'b0;
      failst_q <= 1'b0;
      ref_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      tmr_q    <= tmr_d;
      pls_q    <= pls_d;
      dir_q    <= dir_d;
      ocmd_q   <= ocmd_d;
      ccmd_q   <= ccmd_d;
      sws_q    <= sws_d;
      failst_q <= failst_d;
      ref_q    <= ref_d;
    end
  end

  // Operated pulse and unintended-operation detection on position change
  logic        popen_q, pclose_q, chg;
  logic [15:0] opr_q, opr_d;
  logic        oprv_q, oprv_d, self_q, self_d, rcmd_q, rcmd_d, busy;
  logic        seen_q, seen_d;   // An end position has been held since reset
  assign chg  = (f_open != popen_q) || (f_closed != pclose_q);
  assign busy = st_q != bcc_pkg::BCC_IDLE;
  always_comb begin
    opr_d  = (tick_q && opr_q != 16'h0000) ? opr_q - 16'h0001 : opr_q;
    rcmd_d = busy ? (rcmd_q | req_remote) : req_remote;
    self_d = self_q;
    seen_d = seen_q | f_open | f_closed;
    // First end position after reset is not an operation: avoids a false event
    if (chg && (f_open || f_closed) && seen_q) begin
      opr_d  = bcc_pkg::OPERATED_MS;
      self_d = !(busy && rcmd_q) && !s_trip;
    end
    oprv_d = opr_d != 16'h0000;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      popen_q  <= 1'b0;
      pclose_q <= 1'b0;
      opr_q    <= '0;
      oprv_q   <= 1'b0;
      self_q   <= 1'b0;
      rcmd_q   <= 1'b0;
      seen_q   <= 1'b0;
    end else begin
      seen_q   <= seen_d;
      popen_q  <= f_open;
      pclose_q <= f_closed;
      opr_q    <= opr_d;
      oprv_q   <= oprv_d;
      self_q   <= self_d;
      rcmd_q   <= rcmd_d;
    end
  end

  // Outputs straight from flops
  assign open_command_pulse   = ocmd_q;
  assign close_command_pulse  = ccmd_q;
  assign synchroswitch_start  = sws_q;
  assign operated             = oprv_q;
  assign unintended_operation = self_q;
  assign opened               = f_open;
  assign closed               = f_closed;
  assign intermediate         = f_interm;
  assign bad_position         = f_bad;
  assign operation_failed     = failst_q;
  assign command_refused      = ref_q;
  logic sel_q;
  always_ff @(posedge core_clk) begin
    if (!rstn) sel_q <= 1'b0;
    else       sel_q <= (st_d == bcc_pkg::BCC_SELECTED);
  end
  assign selected = sel_q;

endmodule : bcc_breaker_ctrl

/* File: bcc_breaker_ctrl_assertions.sv */
// Checker on breaker command control ports: permits, pulse length, flags.
// Assumes permits and settings stay steady around each request.
`timescale 1ns/1ps
module bcc_ctrl_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Permits and settings
  input wire logic        open_permit,
  input wire logic        close_permit,
  input wire logic        operation_block,
  input wire logic [1:0]  switching_control_model,
  input wire logic [15:0] pulse_time_ms,
  input wire logic [15:0] synchroswitch_wait_time,
  // Block outputs
  input wire logic        open_command_pulse,
  input wire logic        close_command_pulse,
  input wire logic        synchroswitch_start,
  input wire logic        operated,
  input wire logic        operation_failed
);
  logic [31:0] hi_q, hi_d;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // Cycles a command has stood; one tick of slack covers tick jitter
  always_comb begin
    hi_d = (rstn && (open_command_pulse || close_command_pulse)) ?
           hi_q + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge core_clk) begin
    hi_q <= hi_d;
  end
  a_open_permit: assert property ($rose(open_command_pulse) |-> $past(open_permit, 3))
    else $error("open command without permit");
  a_close_permit: assert property ($rose(close_command_pulse) |-> $past(close_permit, 3))
    else $error("close command without permit");
  a_block_quiet: assert property ($rose(open_command_pulse || close_command_pulse)
    |-> !$past(operation_block, 3))
    else $error("command while blocked");
  a_pulse_len: assert property (hi_q <= ({16'h0000, pulse_time_ms} + 32'h0000_0001)
    * bcc_pkg::TICK_CYCLES)
    else $error("command pulse too long");
  a_cmd_excl: assert property (!(open_command_pulse && close_command_pulse))
    else $error("open and close together");
  a_sw_off: assert property (synchroswitch_wait_time == 16'h0000 |-> !synchroswitch_start)
    else $error("synchroswitch while disabled");
  a_normal_nofail: assert property ($rose(operation_failed)
    |-> switching_control_model != 2'h0)
    else $error("failure flagged in normal model");
  a_operated_len: assert property ($rose(operated) |=> operated [*8])
    else $error("operated pulse too short");
  c_open: cover property ($rose(open_command_pulse));
  c_close: cover property ($rose(close_command_pulse));
  c_fail: cover property ($rose(operation_failed));
endmodule : bcc_ctrl_chk

bind bcc_breaker_ctrl bcc_ctrl_chk i_bcc_ctrl_chk (
  .core_clk, .rstn, .open_permit, .close_permit, .operation_block,
  .switching_control_model, .pulse_time_ms, .synchroswitch_wait_time,
  .open_command_pulse, .close_command_pulse, .synchroswitch_start,
  .operated, .operation_failed
);

/* File: bcc_breaker_model.sv */
// Breaker contact model: travels 500 cycles per command, or sticks.
// Assumes command pulses from the block and a one-cycle flip from the bench.
`timescale 1ns/1ps
module bcc_breaker_model (
  // Clock
  input wire logic core_clk,
  // Bench controls
  input wire logic respond,
  input wire logic flip,
  // Commands and contacts
  input wire logic open_cmd,
  input wire logic close_cmd,
  output logic     open_fb,
  output logic     closed_fb
);
  logic [9:0] run_q = 10'h000;
  logic [9:0] run_d;
  logic       pos_q = 1'b0;
  logic       pos_d;
  // Travel only against the present position; no contact made meanwhile
  always_comb begin
    run_d = (respond && (pos_q ? open_cmd : close_cmd)) ? run_q + 10'h001 : 10'h000;
    pos_d = pos_q ^ flip ^ (run_q == 10'h1F4);
  end
  always_ff @(posedge core_clk) begin
    run_q <= run_d;
    pos_q <= pos_d;
  end
  assign closed_fb = pos_q && run_q == 10'h000;
  assign open_fb   = !pos_q && run_q == 10'h000;
endmodule : bcc_breaker_model

/* File: bcc_testbench.sv */
// Testbench: breaker command control against a breaker contact model.
// Assumes the fixed 1 ms tick; settings kept to a few ms to bound run time.
`timescale 1ns/1ps
module testbench;
  localparam int TC = bcc_pkg::TICK_CYCLES;
  // Clock, reset, sources and requests
  logic        core_clk = 1'b0, rstn = 1'b0, local_enable = 1'b1, remote_enable = 1'b1;
  logic        local_select = 1'b0, remote_select = 1'b0, local_open_req = 1'b0;
  logic        local_close_req = 1'b0, remote_open_req = 1'b0, remote_close_req = 1'b0;
  // Settings in ms
  logic [1:0]  switching_control_model = 2'h0;
  logic [15:0] oper_time_ms = 16'h0003, pulse_time_ms = 16'h0002, interm_time_ms = 16'h0001;
  logic [15:0] sync_wait_time = 16'h0001, synchroswitch_wait_time = 16'h0000;
  logic [15:0] select_timeout = 16'h0001;
  // Interlocking: permits true, block off, unless a test says otherwise
  logic        sync_permit = 1'b1, open_permit = 1'b1, close_permit = 1'b1;
  logic        operation_block = 1'b0, synchroswitch_pulse = 1'b0;
  logic        external_trip_in = 1'b0, respond = 1'b0, flip = 1'b0;
  // Block outputs
  logic        open_feedback, closed_feedback, open_command_pulse, close_command_pulse;
  logic        synchroswitch_start, operated, unintended_operation, opened, closed;
  logic        intermediate, bad_position, selected, operation_failed, command_refused;
  int          error_cnt = 0, cmp_count = 0;

  // Clock at 125 MHz
  always #4 core_clk = ~core_clk;

  bcc_breaker_ctrl i_bcc_breaker_ctrl (.core_clk, .rstn, .local_enable, .remote_enable,
    .local_select, .remote_select, .local_open_req, .local_close_req, .remote_open_req,
    .remote_close_req, .switching_control_model, .oper_time_ms, .pulse_time_ms,
    .interm_time_ms, .sync_wait_time, .synchroswitch_wait_time, .select_timeout,
    .sync_permit, .synchroswitch_pulse, .open_permit, .close_permit, .operation_block,
    .open_feedback, .closed_feedback, .external_trip_in, .open_command_pulse,
    .close_command_pulse, .synchroswitch_start, .operated, .unintended_operation, .opened,
    .closed, .intermediate, .bad_position, .selected, .operation_failed, .command_refused);
  bcc_breaker_model i_bcc_breaker_model (.core_clk, .respond, .flip,
    .open_cmd(open_command_pulse), .close_cmd(close_command_pulse),
    .open_fb(open_feedback), .closed_fb(closed_feedback));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits n edges, then lets their updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // One-cycle pulse: 0 lo, 1 lc, 2 ro, 3 rc, 4 local select
  task automatic req(input int which);
    @(posedge core_clk);
    {local_select, remote_close_req, remote_open_req, local_close_req,
     local_open_req} <= 5'h01 << which;
    @(posedge core_clk);
    {local_select, remote_close_req, remote_open_req, local_close_req, local_open_req} <= 5'h00;
  endtask : req
  // Records {synchroswitch start, refused, command} seen over n cycles
  task automatic watch(input int n, output logic [2:0] s);
    s = 3'h0;
    repeat (n) begin
      cyc(1);
      s |= {synchroswitch_start, command_refused, open_command_pulse | close_command_pulse};
    end
  endtask : watch
  // Delay to the command rising, capped at 3 ms, then its width
  task automatic measure(output int d, output int w);
    d = 0;
    w = 0;
    while (!(open_command_pulse | close_command_pulse) && d < 3 * TC) begin
      cyc(1);
      d++;
    end
    while ((open_command_pulse | close_command_pulse) === 1'b1) begin
      cyc(1);
      w++;
    end
  endtask : measure

  // Normal model: open passes though already open, no supervision after
  task automatic t_normal;
    int d, w;
    req(0);
    measure(d, w);
    chk(16'(d), 16'h0001);
    chk(16'(w > TC && w <= 3 * TC), 16'h0001);
    cyc(2 * TC);
    chk(operation_failed, 16'h0000);
  endtask : t_normal
  // Block on, open permit off, close permit off: each request refused
  task automatic t_refuse;
    logic [2:0] s;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      operation_block <= (i == 0);
      open_permit <= (i != 1);
      close_permit <= (i != 2);
      cyc(4);
      req(i == 2 ? 1 : 0);
      watch(6, s);
      chk({s[1], s[0]}, 16'h0002);
    end
    @(posedge core_clk);
    {operation_block, open_permit, close_permit} <= 3'h3;
  endtask : t_refuse
  // Enhanced close succeeds early; a second close finds it closed
  task automatic t_enh;
    int d, w;
    logic [2:0] s;
    @(posedge core_clk);
    switching_control_model <= 2'h1;
    respond <= 1'b1;
    req(3);
    measure(d, w);
    chk(16'(w > 0 && w < TC), 16'h0001);
    cyc(10);
    chk(closed, 16'h0001);
    chk(operated, 16'h0001);
    chk(operation_failed, 16'h0000);
    req(3);
    watch(6, s);
    chk(s, 16'h0002);
  endtask : t_enh
  // Stuck breaker: failure only once the operating time has run out
  task automatic t_fail;
    @(posedge core_clk);
    respond <= 1'b0;
    req(2);
    cyc(2 * TC);
    chk(operation_failed, 16'h0000);
    cyc(2 * TC);
    chk(operation_failed, 16'h0001);
  endtask : t_fail
  // Selection lapses and the command is dropped; then a timely open
  task automatic t_sbo;
    int d, w;
    logic [2:0] s;
    @(posedge core_clk);
    switching_control_model <= 2'h2;
    respond <= 1'b1;
    req(4);
    cyc(4);
    chk(selected, 16'h0001);
    cyc(2 * TC);
    chk(selected, 16'h0000);
    req(0);
    watch(10, s);
    chk(s[0], 16'h0000);
    req(4);
    cyc(4);
    req(0);
    measure(d, w);
    cyc(10);
    chk(opened, 16'h0001);
  endtask : t_sbo
  // No synchronism: close withheld, synchroswitch only when its time is set
  task automatic t_sync;
    logic [2:0] s;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      switching_control_model <= 2'h1;
      sync_permit <= 1'b0;
      synchroswitch_wait_time <= 16'(i);
      req(1);
      watch(3 * TC, s);
      chk({s[2], s[0]}, 16'(i * 2));
    end
    @(posedge core_clk);
    sync_permit <= 1'b1;
    synchroswitch_wait_time <= 16'h0000;
  endtask : t_sync
  // Position change without command: flagged unless the trip input is on
  task automatic t_self;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      external_trip_in <= (i == 1);
      flip <= 1'b1;
      @(posedge core_clk);
      flip <= 1'b0;
      cyc(20);
      chk(unintended_operation, 16'(i == 0));
    end
  endtask : t_self

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after 20 cycles of reset
  initial begin
    cyc(20);
    @(posedge core_clk);
    rstn <= 1'b1;
    cyc(4);
    chk({unintended_operation, operated, bad_position, intermediate}, 16'h0000);
    t_normal();
    $display("normal model test done");
    t_refuse();
    $display("refusal test done");
    t_enh();
    $display("enhanced close test done");
    t_fail();
    $display("failed operation test done");
    t_sbo();
    $display("select test done");
    t_sync();
    $display("synchronism test done");
    t_self();
    $display("unintended operation test done");
    end_of_test();
  end
  // Watchdog: tests need about 16 ms
  initial begin
    cyc(30 * TC);
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
